// ==== rtl/drive_remote_io_defines.svh ====
`ifndef DRIVE_REMOTE_IO_DEFINES_SVH
`define DRIVE_REMOTE_IO_DEFINES_SVH
// Command word count and slot positions
`define CMD_WORDS 20
`define INSTR_SLOTS 6
`define INSTR_W0 5'h02
`define INSTR_W1 5'h0A
`define INSTR_W2 5'h0C
`define INSTR_W3 5'h0E
`define INSTR_W4 5'h10
`define INSTR_W5 5'h12
// Codes with this upper byte reply an error but are still issued to the drive core
`define INSTR_BAD_HI 8'hFF
`define REPLY_OK 16'h0000
`define REPLY_ERR 16'h0001
// User-defined write window
`define USER_FIRST 5'h04
`define USER_COUNT 4'hE
`define USER_LAST_IDX 4'hD
// Response bound and clock period
`define USER_WR_MAX_NS 100000000
`define CLK_PERIOD_NS 4
// Function select width and "no function" code
`define SEL_W 4
`define SEL_NONE 4'h0
`endif

// ==== rtl/drive_remote_io_pkg.sv ====
package drive_remote_io_pkg;
   // Fault handling sequence
   typedef enum logic [1:0] {
      F_OK,
      F_TRIPPED,
      F_RESETTING
   } fault_state_type;

   // Drive-to-master status bits
   typedef struct packed {
      logic fwd_running_flag;
      logic rev_running_flag;
      logic running_output_bit;
      logic at_speed_bit;
      logic overload_warn_bit;
      logic freq_detect_bit;
      logic fault_output_bit;
      logic gp_out0_bit;
      logic gp_out1_bit;
      logic gp_out2_bit;
      logic fault_status_flag;
      logic instr_exec_done;
   } status_type;

   // One write toward the drive core
   typedef struct packed {
      logic valid;
      logic [15:0] index;
      logic [15:0] data;
   } write_type;

   // Whole block state
   typedef struct packed {
      logic prev_exec;
      logic instr_busy;
      logic [2:0] instr_slot;
      logic [5:0][15:0] reply;
      write_type instr_cmd;
      logic user_busy;
      logic [3:0] user_idx;
      write_type param_wr;
      logic [15:0] op_freq;
      fault_state_type fault_st;
      logic drive_reset;
      logic [15:0] net_func;
      status_type status;
   } state_type;
endpackage

// ==== rtl/drive_remote_io_handshake.sv ====
`timescale 1ns/1ps
`include "drive_remote_io_defines.svh"
module drive_remote_io_handshake #(
   parameter int unsigned USER_WR_MAX_CYC =
      `USER_WR_MAX_NS / `CLK_PERIOD_NS
) (
   input wire logic clk,
   input wire logic rst_n,
   // Cyclic update strobe, one cycle per received frame
   input wire logic update_strobe,
   input wire logic instr_exec_request,
   input wire logic fault_reset_request,
   input wire logic user_param_write_request,
   input wire logic freq_ram_write_cmd,
   input wire logic spare_net_in3,
   input wire logic spare_net_in4,
   input wire logic spare_net_in5,
   input wire logic [19:0][15:0] command_word,
   // Index selections for the fourteen user words
   input wire logic [13:0][15:0] index_select,
   // Operation source allows network control
   input wire logic net_ctrl_allowed,
   // Drive core conditions
   input wire logic fwd_rotating,
   input wire logic rev_rotating,
   input wire logic speed_reached,
   input wire logic overload_alarm,
   input wire logic protective_trip,
   input wire logic [15:0] func_src,
   // Output and input assignment selects
   input wire logic [`SEL_W-1:0] run_sel,
   input wire logic [`SEL_W-1:0] fdet_sel,
   input wire logic [`SEL_W-1:0] fault_sel,
   input wire logic [2:0][`SEL_W-1:0] gp_sel,
   input wire logic [2:0][`SEL_W-1:0] spare_in_sel,
   // Results toward master and drive core
   output drive_remote_io_pkg::status_type status,
   output logic [5:0][15:0] reply_word,
   output drive_remote_io_pkg::write_type instr_cmd,
   output drive_remote_io_pkg::write_type param_wr,
   output logic [15:0] op_freq,
   output logic drive_reset,
   output logic [15:0] net_func
);
   drive_remote_io_pkg::state_type st;
   drive_remote_io_pkg::state_type next_st;
   // Update-qualified exec edge and raw spare network bits
   logic exec_rise;
   logic [2:0] spare_in;

   // Command word holding instruction code for a slot
   function automatic logic [4:0] slot_word(input logic [2:0] s);
      case (s)
         3'h0: slot_word = `INSTR_W0;
         3'h1: slot_word = `INSTR_W1;
         3'h2: slot_word = `INSTR_W2;
         3'h3: slot_word = `INSTR_W3;
         3'h4: slot_word = `INSTR_W4;
         default: slot_word = `INSTR_W5;
      endcase
   endfunction

   // Pick a function source, code zero gives none
   function automatic logic pick(input logic [`SEL_W-1:0] sel,
                                 input logic [15:0] src);
      pick = (sel == `SEL_NONE) ? 1'b0 : src[sel];
   endfunction

   assign exec_rise = update_strobe && instr_exec_request &&
                      !st.prev_exec;
   assign spare_in = {spare_net_in5, spare_net_in4, spare_net_in3};

   // Next-state logic for the whole block
   always_comb begin
      logic [4:0] w;
      logic [4:0] uw;
      w = slot_word(st.instr_slot);
      uw = 5'(`USER_FIRST + 5'(st.user_idx));
      next_st = st;
      next_st.instr_cmd.valid = 1'b0;
      next_st.param_wr.valid = 1'b0;
      next_st.drive_reset = 1'b0;
      // Remember request level at each update
      if (update_strobe) begin
         next_st.prev_exec = instr_exec_request;
      end
      // Request low drops completion
      if (update_strobe && !instr_exec_request) begin
         next_st.status.instr_exec_done = 1'b0;
      end
      // Fresh edge starts the slot walk
      if (exec_rise) begin
         next_st.instr_busy = 1'b1;
         next_st.instr_slot = 3'h0;
         next_st.status.instr_exec_done = 1'b0;
      end else if (st.instr_busy) begin
         // Issue one slot per cycle
         next_st.instr_cmd.valid = 1'b1;
         next_st.instr_cmd.index = command_word[w];
         next_st.instr_cmd.data = command_word[5'(w + 5'h01)];
         if (command_word[w][15:8] == `INSTR_BAD_HI) begin
            next_st.reply[st.instr_slot] = `REPLY_ERR;
         end else begin
            next_st.reply[st.instr_slot] = `REPLY_OK;
         end
         if (st.instr_slot == 3'(`INSTR_SLOTS - 1)) begin
            next_st.instr_busy = 1'b0;
            next_st.status.instr_exec_done = 1'b1;
         end else begin
            next_st.instr_slot = 3'(st.instr_slot + 3'h1);
         end
      end
      // User words sweep, started on a requested update only when idle
      if (st.user_busy) begin
         next_st.param_wr.valid = 1'b1;
         next_st.param_wr.index = index_select[st.user_idx];
         next_st.param_wr.data = command_word[uw];
         if (st.user_idx == `USER_LAST_IDX) begin
            next_st.user_busy = 1'b0;
         end else begin
            next_st.user_idx = 4'(st.user_idx + 4'h1);
         end
      end else if (update_strobe && user_param_write_request) begin
         next_st.user_busy = 1'b1;
         next_st.user_idx = 4'h0;
      end
      // Held RAM frequency command
      if (update_strobe && freq_ram_write_cmd && net_ctrl_allowed) begin
         next_st.op_freq = command_word[1];
      end
      // Spare inputs drive their assigned functions
      if (update_strobe) begin
         next_st.net_func = '0;
         for (int i = 0; i < 3; i++) begin
            if (spare_in_sel[i] != `SEL_NONE && spare_in[i] &&
                net_ctrl_allowed) begin
               next_st.net_func[spare_in_sel[i]] = 1'b1;
            end
         end
      end
      // Fault sequence, a trip always wins
      case (st.fault_st)
         drive_remote_io_pkg::F_OK: begin
            if (protective_trip) begin
               next_st.fault_st = drive_remote_io_pkg::F_TRIPPED;
               next_st.status.fault_status_flag = 1'b1;
            end
         end
         drive_remote_io_pkg::F_TRIPPED: begin
            if (update_strobe && fault_reset_request &&
                !protective_trip) begin
               next_st.fault_st = drive_remote_io_pkg::F_RESETTING;
               next_st.drive_reset = 1'b1;
            end
         end
         drive_remote_io_pkg::F_RESETTING: begin
            if (protective_trip) begin
               next_st.fault_st = drive_remote_io_pkg::F_TRIPPED;
            end else begin
               next_st.fault_st = drive_remote_io_pkg::F_OK;
               next_st.status.fault_status_flag = 1'b0;
            end
         end
         default: begin
            next_st.fault_st = drive_remote_io_pkg::F_OK;
         end
      endcase
      // Direction and fixed status bits
      next_st.status.fwd_running_flag =
         fwd_rotating && !rev_rotating;
      next_st.status.rev_running_flag =
         rev_rotating && !fwd_rotating;
      next_st.status.at_speed_bit = speed_reached;
      next_st.status.overload_warn_bit = overload_alarm;
      // Assignable status bits
      next_st.status.running_output_bit = pick(run_sel, func_src);
      next_st.status.freq_detect_bit = pick(fdet_sel, func_src);
      next_st.status.fault_output_bit = pick(fault_sel, func_src);
      next_st.status.gp_out0_bit = pick(gp_sel[0], func_src);
      next_st.status.gp_out1_bit = pick(gp_sel[1], func_src);
      next_st.status.gp_out2_bit = pick(gp_sel[2], func_src);
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state flops
   assign status = st.status;
   assign reply_word = st.reply;
   assign instr_cmd = st.instr_cmd;
   assign param_wr = st.param_wr;
   assign op_freq = st.op_freq;
   assign drive_reset = st.drive_reset;
   assign net_func = st.net_func;

   // Cycles since user write sweep began
   logic [31:0] user_age;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         user_age <= 32'h0;
      end else if (!st.user_busy) begin
         user_age <= 32'h0;
      end else begin
         user_age <= 32'(user_age + 32'h1);
      end
   end

   exec_walk_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      exec_rise |=> st.instr_busy ##0 !instr_cmd.valid ##1
         instr_cmd.valid [*6])
      else $error("slot walk did not issue six commands");
   exec_done_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      exec_rise |-> ##8 status.instr_exec_done ||
         (update_strobe && !instr_exec_request) || exec_rise)
      else $error("completion missing after slot walk");
   reply_err_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      st.instr_busy && command_word[slot_word(st.instr_slot)][15:8]
         == `INSTR_BAD_HI && !exec_rise |=>
      reply_word[$past(st.instr_slot)] != `REPLY_OK)
      else $error("failed slot replied zero");
   fault_clear_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      drive_reset && !protective_trip |=> !status.fault_status_flag)
      else $error("fault flag not cleared after reset");
   user_sweep_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(st.user_busy) |=> param_wr.valid [*8])
      else $error("parameter sweep stalled");
   user_bound_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      user_age < 32'(USER_WR_MAX_CYC))
      else $error("parameter write exceeded response bound");
   freq_apply_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      update_strobe && freq_ram_write_cmd && net_ctrl_allowed |=>
      op_freq == $past(command_word[1]))
      else $error("set frequency not applied");
   dir_excl_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      status.fwd_running_flag |->
         !status.rev_running_flag && $past(fwd_rotating) &&
         !$past(rev_rotating))
      else $error("forward flag without forward-only rotation");
   done_clear_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      update_strobe && !instr_exec_request |=> !status.instr_exec_done)
      else $error("completion stayed high after request dropped");
   trip_flag_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      protective_trip |=> status.fault_status_flag)
      else $error("trip did not raise fault flag");
endmodule

// ==== test/network_master_model.sv ====
`timescale 1ns/1ps
module network_master_model (
   input wire logic clk,
   input wire logic rst_n,
   // Wanted request level from the bench
   input wire logic want_exec,
   output logic update_strobe,
   output logic instr_exec_request
);
   logic [3:0] cnt; // Frame spacing counter

   // One frame every ten cycles, request changes only with a frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 4'h0;
         update_strobe <= 1'b0;
         instr_exec_request <= 1'b0;
      end else begin
         cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
         update_strobe <= (cnt == 4'h9);
         // Request takes the want_exec level only on a frame cycle
         if (cnt == 4'h9) begin
            instr_exec_request <= want_exec;
         end
      end
   end
endmodule

// ==== test/drive_remote_io_handshake_bench.sv ====
`timescale 1ns/1ps
module drive_remote_io_handshake_bench;
   logic clk = 1'b0; // Core clock
   logic rst_n = 1'b0; // Async reset
   logic want_exec = 1'b0; // Master intent
   logic update_strobe, instr_exec_request;
   logic fault_reset_request = 1'b0, user_param_write_request = 1'b0;
   logic freq_ram_write_cmd = 1'b0, net_ctrl_allowed = 1'b1;
   logic [2:0] spare = 3'h0; // Spare network inputs
   logic [19:0][15:0] command_word; // Words from master
   logic [13:0][15:0] index_select; // Target indexes
   logic fwd_rotating = 1'b0, rev_rotating = 1'b0, protective_trip = 1'b0;
   logic speed_reached = 1'b0, overload_alarm = 1'b0;
   logic [15:0] func_src = 16'h0000; // Drive function sources
   logic [3:0] run_sel = 4'h0, fdet_sel = 4'h0, fault_sel = 4'h0;
   logic [2:0][3:0] gp_sel = 12'h000, spare_in_sel = 12'h000;
   drive_remote_io_pkg::status_type status;
   logic [5:0][15:0] reply_word;
   drive_remote_io_pkg::write_type instr_cmd, param_wr, last_i, last_p;
   logic [15:0] op_freq, net_func;
   logic drive_reset;
   int err_count = 0, num_checks = 0;
   int n_i = 0, n_p = 0, n_r = 0; // Pulse tallies

   // Free-running clock
   always #2 clk = ~clk;

   // Tally one-cycle pulses and keep the last write seen
   always @(posedge clk) begin
      if (instr_cmd.valid === 1'b1) begin
         n_i <= n_i + 1;
         last_i <= instr_cmd;
      end
      if (param_wr.valid === 1'b1) begin
         n_p <= n_p + 1;
         last_p <= param_wr;
      end
      if (drive_reset === 1'b1) begin
         n_r <= n_r + 1;
      end
   end

   network_master_model master (.clk(clk), .rst_n(rst_n),
      .want_exec(want_exec), .update_strobe(update_strobe),
      .instr_exec_request(instr_exec_request));

   drive_remote_io_handshake #(.USER_WR_MAX_CYC(64)) dut (.clk(clk),
      .rst_n(rst_n), .update_strobe(update_strobe),
      .instr_exec_request(instr_exec_request),
      .fault_reset_request(fault_reset_request),
      .user_param_write_request(user_param_write_request),
      .freq_ram_write_cmd(freq_ram_write_cmd), .spare_net_in3(spare[0]),
      .spare_net_in4(spare[1]), .spare_net_in5(spare[2]),
      .command_word(command_word), .index_select(index_select),
      .net_ctrl_allowed(net_ctrl_allowed), .fwd_rotating(fwd_rotating),
      .rev_rotating(rev_rotating), .speed_reached(speed_reached),
      .overload_alarm(overload_alarm), .protective_trip(protective_trip),
      .func_src(func_src), .run_sel(run_sel), .fdet_sel(fdet_sel),
      .fault_sel(fault_sel), .gp_sel(gp_sel), .spare_in_sel(spare_in_sel),
      .status(status), .reply_word(reply_word), .instr_cmd(instr_cmd),
      .param_wr(param_wr), .op_freq(op_freq), .drive_reset(drive_reset),
      .net_func(net_func));

   // Print counts and verdict, then stop
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // One compare
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Bounded wait for done (0) or fault flag (1) to reach a level
   task automatic wait_bit(input int sel, input logic val);
      for (int i = 0; i < 200; i++) begin
         @(posedge clk);
         if ((sel == 0 ? status.instr_exec_done : status.fault_status_flag)
             === val) return;
      end
      err_count++;
      $display("MISMATCH wait expected %b seen timeout", val);
      report_and_stop();
   endtask

   // Outputs quiet after reset, spare inputs idle
   task automatic t_reset();
      chk("status", 16'h0000, {4'h0, status});
      chk("net_func", 16'h0000, net_func);
      chk("op_freq", 16'h0000, op_freq);
   endtask

   // Six slots run on a rising edge, one fails, done follows request
   task automatic t_instr();
      int base;
      base = n_i;
      command_word[2] <= 16'hFF01;
      want_exec <= 1'b1;
      wait_bit(0, 1'b1);
      cyc(2);
      chk("slots", 16'h0006, 16'(n_i - base));
      chk("code", command_word[18], last_i.index);
      chk("data", command_word[19], last_i.data);
      chk("reply0", 16'h0001, reply_word[0]);
      for (int s = 1; s < 6; s++) begin
         chk("reply", 16'h0000, reply_word[s]);
      end
      want_exec <= 1'b0;
      wait_bit(0, 1'b0);
      cyc(30);
      chk("no rerun", 16'h0006, 16'(n_i - base));
   endtask

   // Trip sets flag, reset request after trip clears it once
   task automatic t_fault();
      protective_trip <= 1'b1;
      cyc(3);
      chk("flag", 16'h0001, {15'h0, status.fault_status_flag});
      protective_trip <= 1'b0;
      fault_reset_request <= 1'b1;
      wait_bit(1, 1'b0);
      fault_reset_request <= 1'b0;
      cyc(2);
      chk("drive_reset", 16'h0001, 16'(n_r));
   endtask

   // Whole sweeps repeat while the write request is held
   task automatic t_user();
      int base;
      base = n_p;
      user_param_write_request <= 1'b1;
      cyc(45);
      user_param_write_request <= 1'b0;
      cyc(30);
      chk("whole", 16'h0000, 16'((n_p - base) % 14));
      chk("repeat", 16'h0001, 16'(n_p - base >= 28));
      chk("index", index_select[13], last_p.index);
      chk("value", command_word[17], last_p.data);
   endtask

   // Held frequency command applies, ignored when source excludes network
   task automatic t_freq();
      command_word[1] <= 16'h1234;
      freq_ram_write_cmd <= 1'b1;
      spare <= 3'h1;
      spare_in_sel[0] <= 4'h3;
      cyc(25);
      chk("op_freq", 16'h1234, op_freq);
      chk("net_func", 16'h0008, net_func);
      net_ctrl_allowed <= 1'b0;
      command_word[1] <= 16'h5678;
      cyc(25);
      chk("op_freq held", 16'h1234, op_freq);
      chk("net_func off", 16'h0000, net_func);
   endtask

   // Direction flags, fixed bits and assigned outputs
   task automatic t_status();
      fwd_rotating <= 1'b1;
      speed_reached <= 1'b1;
      overload_alarm <= 1'b1;
      func_src <= 16'h0005;
      run_sel <= 4'h2;
      gp_sel <= 12'h222;
      cyc(3);
      chk("fwd", 16'h0001, {15'h0, status.fwd_running_flag});
      chk("rev", 16'h0000, {15'h0, status.rev_running_flag});
      chk("fixed", 16'h0003, {14'h0, status.at_speed_bit,
                              status.overload_warn_bit});
      chk("assign", 16'h0001, {15'h0, status.running_output_bit});
      chk("no func", 16'h0000, {14'h0, status.freq_detect_bit,
                                status.fault_output_bit});
      chk("gp", 16'h0007, {13'h0, status.gp_out0_bit,
                           status.gp_out1_bit, status.gp_out2_bit});
      rev_rotating <= 1'b1;
      cyc(3);
      chk("both", 16'h0000, {14'h0, status.fwd_running_flag,
                             status.rev_running_flag});
   endtask

   // Main sequence
   initial begin
      for (int w = 0; w < 20; w++) command_word[w] <= 16'h1000 + 16'(w);
      for (int k = 0; k < 14; k++) index_select[k] <= 16'h0100 + 16'(k);
      cyc(20);
      rst_n <= 1'b1;
      cyc(2);
      t_reset();
      t_instr();
      t_fault();
      t_user();
      t_freq();
      t_status();
      report_and_stop();
   end
endmodule
